// file: bench/panel_rail_sequencer_test.sv
// self-checking bench for the panel rail sequencer
module panel_rail_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   import prs_pkg::*;
   localparam int TK = 4;
   logic clk_i = 0, reset_n_i = 0, load_done_i = 0;
   logic scl_i, sda_i, sda_o, sda_oe_n_o, pos_precharge_done_i, neg_source_ready_i;
   logic pump_ext_mode_o, pos_source_run_o, low_gate_run_o, low_gate_ramping_o;
   logic low_gate_ready_o, neg_source_run_o, neg_source_ramping_o;
   logic [5:0] pos_source_level_o, high_gate_level_o, low_gate_level_o;
   logic [4:0] cold_gate_offset_o;
   logic [2:0] low_gate_ramp_code_o, neg_source_ramp_code_o;
   int fail_count = 0, num_checks = 0, cyc = 0;
   int t_pos = -1, t_lgr = -1, t_lgd = -1, t_nsr = -1, t_nse = -1;
   prs_sequencer #(.TICK_CYCLES(TK)) i_dut (.*);
   prs_partner i_m (.clk_i, .dev_sda_i(sda_o), .dev_oe_n_i(sda_oe_n_o),
      .pos_run_i(pos_source_run_o), .ns_ramp_i(neg_source_ramping_o), .scl_o(scl_i),
      .sda_wire_o(sda_i), .prechg_o(pos_precharge_done_i), .ready_o(neg_source_ready_i));
   // cycle stamps of each sequence step, counted from the load
   always @(posedge clk_i) begin
      if (load_done_i) cyc++;
      if (pos_source_run_o && t_pos < 0) t_pos = cyc;
      if (low_gate_run_o && low_gate_ramping_o && t_lgr < 0) t_lgr = cyc;
      if (low_gate_ready_o && t_lgd < 0) t_lgd = cyc;
      if (neg_source_run_o && neg_source_ramping_o && t_nsr < 0) t_nsr = cyc;
      if (neg_source_ready_i && !neg_source_ramping_o && t_nse < 0) t_nse = cyc;
   end
   task automatic check(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %0t: saw %h want %h", $time, s, e);
      end
   endtask
   function automatic logic [7:0] near(input int t, input int d);
      return {7'h0, t >= d && t <= d + 8};
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic t_reset;
      check(high_gate_level_o, RST_HG_LEVEL);
      check(cold_gate_offset_o, RST_HG_COLD);
      check(low_gate_level_o, RST_LG_LEVEL);
      check(low_gate_ramp_code_o, RST_LG_RAMP);
      check(neg_source_ramp_code_o, RST_NS_RAMP);
      check(pos_source_level_o, RST_POS_LEVEL);
      check({7'h0, pump_ext_mode_o}, {7'h0, RST_PUMP_CFG[PUMP_EXT_BIT]});
   endtask
   task automatic t_regs;
      logic [7:0] rv;
      i_m.wr(OFS_HG_LEVEL, 8'hff);
      check(high_gate_level_o, 8'h3f);
      i_m.wr(OFS_HG_LEVEL, 8'h00);
      check(high_gate_level_o, 8'((RST_POS_LEVEL * PS_STEP_MV + PS_BASE_MV + HG_MARGIN_MV
         - HG_BASE_MV + HG_STEP_MV - 1) / HG_STEP_MV));
      i_m.wr(OFS_PUMP_CFG, 8'h20);
      check(pump_ext_mode_o, 8'h01);
      i_m.wr(OFS_LG_RAMP, 8'hff);
      check(low_gate_ramp_code_o, 8'h07);
      i_m.wr(OFS_LG_DELAY, 8'h00);
      i_m.rd(rv);
      check(rv, 8'hff & MSK_RAMP);
      check(8'(i_m.nacks), 8'h00);
   endtask
   task automatic t_seq(input int gap, input int ramp);
      @(negedge clk_i);
      load_done_i = 1'b1;
      for (int i = 0; i < 400 && (t_lgd < 0 || t_nse < 0); i++) @(negedge clk_i);
      check(near(t_pos, RST_POS_DELAY * DELAY_STEP_MS * TK), 8'h01);
      check(near(t_lgr - t_pos, gap), 8'h01);
      check(near(t_lgd - t_lgr, ramp), 8'h01);
      check(low_gate_ramping_o, 8'h00);
      check(neg_source_ramping_o, 8'h00);
      check(near(t_nsr, RST_NS_DELAY * DELAY_STEP_MS * TK), 8'h01);
      check(near(t_nse - t_nsr, 30), 8'h01);
   endtask
   // second reset after the first sequence, default low gate delay and ramp
   task automatic t_rerun;
      @(negedge clk_i);
      reset_n_i = 1'b0;
      load_done_i = 1'b0;
      repeat (5) @(negedge clk_i);
      reset_n_i = 1'b1;
      cyc = 0;
      t_pos = -1;
      t_lgr = -1;
      t_lgd = -1;
      t_nsr = -1;
      t_nse = -1;
      repeat (3) @(negedge clk_i);
      t_reset;
      t_seq(RST_LG_DELAY * DELAY_STEP_MS * TK, (RST_LG_RAMP + 1) * LG_RAMP_STEP_MS * TK);
   endtask
   initial forever #5 clk_i = ~clk_i;
   initial begin
      repeat (5) @(negedge clk_i);
      reset_n_i = 1'b1;
      repeat (3) @(negedge clk_i);
      t_reset;
      t_regs;
      t_seq(10, 8 * LG_RAMP_STEP_MS * TK);
      t_rerun;
      tally_and_finish;
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      fail_count++;
      tally_and_finish;
   end
endmodule

// file: bench/prs_partner.sv
// serial host and rail regulator models facing the rail sequencer
module prs_partner import prs_pkg::*; (
   input  wire logic clk_i, dev_sda_i, dev_oe_n_i, pos_run_i, ns_ramp_i,
   output logic      scl_o = 1'b1, sda_wire_o, prechg_o = 1'b0, ready_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic sda_h = 1'b1;
   int n_pc = 0, n_rd = 0, nacks = 0;
   // open drain line with a pull-up
   assign sda_wire_o = sda_h & (dev_oe_n_i | dev_sda_i);
   task automatic step(input logic s, input logic d);
      @(negedge clk_i);
      scl_o = s;
      sda_h = d;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic send(input logic b);
      step(1'b0, sda_h);
      step(1'b0, b);
      step(1'b1, b);
   endtask
   // one register write; a missing ack is counted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [23:0] f;
      f = {DEV_ADDR, 1'b0, a, d};
      step(1'b1, 1'b0);
      for (int i = 23; i >= 0; i--) begin
         send(f[i]);
         if (i % 8 == 0) begin
            send(1'b1);
            nacks += int'(sda_wire_o !== 1'b0);
         end
      end
      send(1'b0);
      step(1'b1, 1'b1);
   endtask
   // one read at the current pointer, closed by a nack
   task automatic rd(output logic [7:0] d);
      logic [7:0] f;
      f = {DEV_ADDR, 1'b1};
      step(1'b1, 1'b0);
      for (int i = 7; i >= 0; i--) begin
         send(f[i]);
      end
      send(1'b1);
      nacks += int'(sda_wire_o !== 1'b0);
      for (int i = 7; i >= 0; i--) begin
         send(1'b1);
         d[i] = sda_wire_o;
      end
      send(1'b1);
      send(1'b0);
      step(1'b1, 1'b1);
   endtask
   // precharge 10 cycles after the source runs, ready 30 cycles into the ramp, cleared at reset
   always @(negedge clk_i) begin
      n_pc <= pos_run_i ? n_pc + 1 : 0;
      n_rd <= ns_ramp_i ? n_rd + 1 : (pos_run_i ? n_rd : 0);
      prechg_o <= n_pc >= 10;
      ready_o <= n_rd >= 30;
   end
endmodule

// file: common/prs_pkg.sv
// constants, register map and state types of the panel rail sequencer
package prs_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS   = 10;
   localparam int TICK_TIME_NS    = 1000000;
   localparam int TICK_CYCLES     = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_STEP_MS   = 5;
   localparam int LG_RAMP_STEP_MS = 3;

   // ****************************************************************
   // serial interface
   // ****************************************************************
   // arbitrary neutral value
   localparam logic [6:0] DEV_ADDR = 7'h2a;

   // ****************************************************************
   // register offsets, reset values and implemented bits
   // ****************************************************************
   localparam logic [7:0] OFS_POS_LEVEL    = 8'h00;
   localparam logic [7:0] OFS_HG_LEVEL     = 8'h02;
   localparam logic [7:0] OFS_LG_LEVEL     = 8'h03;
   localparam logic [7:0] OFS_HG_COLD      = 8'h06;
   localparam logic [7:0] OFS_POS_DELAY    = 8'h07;
   localparam logic [7:0] OFS_LG_DELAY     = 8'h09;
   localparam logic [7:0] OFS_LG_RAMP      = 8'h0a;
   localparam logic [7:0] OFS_NS_DELAY     = 8'h0d;
   localparam logic [7:0] OFS_NS_RAMP      = 8'h0e;
   localparam logic [7:0] OFS_PUMP_CFG     = 8'h14;

   localparam logic [7:0] RST_POS_LEVEL    = 8'h22;
   localparam logic [7:0] RST_HG_LEVEL     = 8'h06;
   localparam logic [7:0] RST_LG_LEVEL     = 8'h10;
   localparam logic [7:0] RST_HG_COLD      = 8'h00;
   localparam logic [7:0] RST_POS_DELAY    = 8'h01;
   localparam logic [7:0] RST_LG_DELAY     = 8'h05;
   localparam logic [7:0] RST_LG_RAMP      = 8'h02;
   localparam logic [7:0] RST_NS_DELAY     = 8'h03;
   localparam logic [7:0] RST_NS_RAMP      = 8'h01;
   localparam logic [7:0] RST_PUMP_CFG     = 8'h00;

   localparam logic [7:0] MSK_LEVEL6       = 8'h3f;
   localparam logic [7:0] MSK_COLD         = 8'h1f;
   localparam logic [7:0] MSK_DELAY        = 8'h0f;
   localparam logic [7:0] MSK_RAMP         = 8'h07;
   localparam logic [7:0] MSK_PUMP         = 8'h20;
   localparam int         PUMP_EXT_BIT     = 5;

   localparam int NUM_REGS = 10;
   localparam int IDX_POS_LEVEL = 0;
   localparam int IDX_HG_LEVEL  = 1;
   localparam int IDX_LG_LEVEL  = 2;
   localparam int IDX_HG_COLD   = 3;
   localparam int IDX_POS_DELAY = 4;
   localparam int IDX_LG_DELAY  = 5;
   localparam int IDX_LG_RAMP   = 6;
   localparam int IDX_NS_DELAY  = 7;
   localparam int IDX_NS_RAMP   = 8;
   localparam int IDX_PUMP_CFG  = 9;

   localparam logic [7:0] REG_OFS [NUM_REGS] = '{OFS_POS_LEVEL, OFS_HG_LEVEL, OFS_LG_LEVEL,
      OFS_HG_COLD, OFS_POS_DELAY, OFS_LG_DELAY, OFS_LG_RAMP, OFS_NS_DELAY, OFS_NS_RAMP,
      OFS_PUMP_CFG};
   localparam logic [7:0] REG_RST [NUM_REGS] = '{RST_POS_LEVEL, RST_HG_LEVEL, RST_LG_LEVEL,
      RST_HG_COLD, RST_POS_DELAY, RST_LG_DELAY, RST_LG_RAMP, RST_NS_DELAY, RST_NS_RAMP,
      RST_PUMP_CFG};
   localparam logic [7:0] REG_MSK [NUM_REGS] = '{MSK_LEVEL6, MSK_LEVEL6, MSK_LEVEL6,
      MSK_COLD, MSK_DELAY, MSK_DELAY, MSK_RAMP, MSK_DELAY, MSK_RAMP, MSK_PUMP};

   // ****************************************************************
   // level arithmetic in millivolts
   // ****************************************************************
   localparam int HG_BASE_MV   = 7000;
   localparam int HG_STEP_MV   = 500;
   localparam int PS_BASE_MV   = 5000;
   localparam int PS_STEP_MV   = 50;
   localparam int HG_MARGIN_MV = 2000;

   // ****************************************************************
   // state types
   // ****************************************************************
   typedef enum logic [2:0] {S_IDLE, S_DELAY, S_WAIT, S_RAMP, S_DONE} prs_seq_e;
   typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WR, I_RD} prs_i2c_e;

endpackage

// file: rtl/prs_ms_timer.sv
// millisecond interval timer with a done strobe
module prs_ms_timer #(
   parameter int TICK_CYCLES = prs_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // control
   input  wire logic       start_i,
   input  wire logic [7:0] ms_i,
   // status
   output logic            busy_o,
   output logic            done_o
);
   import prs_pkg::*;

   localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   typedef struct packed {
      logic          busy;
      logic          done;
      logic [7:0]    ms_left;
      logic [CW-1:0] cyc;
   } prs_tmr_s;

   prs_tmr_s s_r;
   prs_tmr_s s_nxt;

   // ****************************************************************
   // counting
   // ****************************************************************
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (start_i) begin
         s_nxt.busy    = (ms_i != 8'h00);
         s_nxt.done    = (ms_i == 8'h00);
         s_nxt.ms_left = ms_i;
         s_nxt.cyc     = '0;
      end else if (s_r.busy) begin
         if (s_r.cyc == CW'(TICK_CYCLES - 1)) begin
            s_nxt.cyc     = '0;
            s_nxt.ms_left = s_r.ms_left - 8'h01;
            if (s_r.ms_left == 8'h01) begin
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
            end
         end else begin
            s_nxt.cyc = s_r.cyc + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy_o = s_r.busy;
   assign done_o = s_r.done;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   chk_zero_done: assert property (start_i && ms_i == 8'h00 |=> done_o && !busy_o)
      else $error("zero interval did not finish at once");
   chk_busy_hold: assert property (start_i && ms_i != 8'h00 |=> busy_o && !done_o)
      else $error("nonzero interval finished at once");

endmodule

// file: rtl/prs_sequencer.sv
// panel rail sequencer: serial register slave, level codes and power-on order
// Summary of operation
// - high gate level code, six bits, reset 10 V
// - raise high gate target two volts over source
// - cold offset code, five bits, reset zero
// - low gate level code, six bits, reset -10 V
// - pump topology bit selects internal or external
// - low gate ramp code, 3 ms steps, reset 9 ms
// - time low gate ramp until level reached
// - low gate delay code, 5 ms steps, reset 25 ms
// - low gate delay starts with positive source ramp
// - zero delay waits for positive precharge done
// - negative source delay code, reset 15 ms
// - negative source delay starts after settings load
// - negative source ramp code, reset 10 ms
// - negative source ramp ends on ready signal
// - positive source delay starts after settings load
module prs_sequencer #(
   parameter int TICK_CYCLES = prs_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   // serial register port
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_n_o,
   // sequence inputs
   input  wire logic       load_done_i,
   input  wire logic       pos_precharge_done_i,
   input  wire logic       neg_source_ready_i,
   // level and ramp codes and pump mode
   output logic [5:0]      pos_source_level_o,
   output logic [5:0]      high_gate_level_o,
   output logic [4:0]      cold_gate_offset_o,
   output logic [5:0]      low_gate_level_o,
   output logic            pump_ext_mode_o,
   output logic [2:0]      low_gate_ramp_code_o,
   output logic [2:0]      neg_source_ramp_code_o,
   // sequence outputs
   output logic            pos_source_run_o,
   output logic            low_gate_run_o,
   output logic            low_gate_ramping_o,
   output logic            low_gate_ready_o,
   output logic            neg_source_run_o,
   output logic            neg_source_ramping_o
);
   import prs_pkg::*;

   localparam int NT = 4;
   localparam int T_POS = 0;
   localparam int T_NS  = 1;
   localparam int T_LGD = 2;
   localparam int T_LGR = 3;

   typedef struct packed {
      logic [1:0]                 scl_sy;
      logic [1:0]                 sda_sy;
      logic [1:0]                 pre_sy;
      logic [1:0]                 rdy_sy;
      logic                       scl_d;
      logic                       sda_d;
      prs_i2c_e                   phase;
      logic                       in_ack;
      logic [3:0]                 bit_cnt;
      logic [7:0]                 shift;
      logic [7:0]                 ptr;
      logic                       drive;
      logic [NUM_REGS-1:0][7:0]   regs;
      prs_seq_e                   pos_st;
      prs_seq_e                   lg_st;
      prs_seq_e                   ns_st;
      logic [5:0]                 hg_eff;
      logic                       pos_run;
      logic                       lg_run;
      logic                       lg_ramping;
      logic                       lg_ready;
      logic                       ns_run;
      logic                       ns_ramping;
   } prs_state_s;

   prs_state_s s_r;
   prs_state_s s_nxt;

   logic [NT-1:0]      tmr_start;
   logic [NT-1:0][7:0] tmr_ms;
   logic [NT-1:0]      tmr_done;
   logic               wr_stb;
   logic [5:0]         hg_min;

   // ****************************************************************
   // register decode
   // ****************************************************************
   // returns {hit, index}
   function automatic logic [4:0] reg_index(input logic [7:0] ofs);
      logic [4:0] res;
      res = 5'h00;
      for (int i = 0; i < NUM_REGS; i++) begin
         if (REG_OFS[i] == ofs) begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction

   // ****************************************************************
   // interval timers
   // ****************************************************************
   for (genvar g = 0; g < NT; g++) begin : g_tmr
      prs_ms_timer #(
         .TICK_CYCLES (TICK_CYCLES)
      ) u_tmr (
         .clk_i       (clk_i),
         .reset_n_i   (reset_n_i),
         .start_i     (tmr_start[g]),
         .ms_i        (tmr_ms[g]),
         .busy_o      (),
         .done_o      (tmr_done[g])
      );
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic       scl_rise;
      logic       scl_fall;
      logic       start_c;
      logic       stop_c;
      logic [4:0] sel;
      logic [7:0] rdata;
      int         need_mv;
      int         min_code;
      scl_rise  = 1'b0;
      scl_fall  = 1'b0;
      start_c   = 1'b0;
      stop_c    = 1'b0;
      sel       = 5'h00;
      rdata     = 8'h00;
      need_mv   = 0;
      min_code  = 0;
      s_nxt     = s_r;
      wr_stb    = 1'b0;
      tmr_start = '0;

      // serial, precharge and ready pin inputs through two flip-flops; load_done_i is used directly
      s_nxt.scl_sy = {s_r.scl_sy[0], scl_i};
      s_nxt.sda_sy = {s_r.sda_sy[0], sda_i};
      s_nxt.pre_sy = {s_r.pre_sy[0], pos_precharge_done_i};
      s_nxt.rdy_sy = {s_r.rdy_sy[0], neg_source_ready_i};
      s_nxt.scl_d  = s_r.scl_sy[1];
      s_nxt.sda_d  = s_r.sda_sy[1];
      scl_rise = s_r.scl_sy[1] & ~s_r.scl_d;
      scl_fall = ~s_r.scl_sy[1] & s_r.scl_d;
      start_c  = s_r.scl_sy[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_sy[1];
      stop_c   = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sy[1];
      sel   = reg_index(s_r.ptr);
      rdata = sel[4] ? s_r.regs[sel[3:0]] : 8'h00;

      // serial byte engine
      if (start_c) begin
         s_nxt.phase   = I_ADDR;
         s_nxt.in_ack  = 1'b0;
         s_nxt.bit_cnt = 4'h0;
         s_nxt.drive   = 1'b0;
      end else if (stop_c) begin
         s_nxt.phase = I_IDLE;
         s_nxt.drive = 1'b0;
      end else if (s_r.phase != I_IDLE && scl_rise) begin
         if (s_r.phase == I_RD) begin
            if (s_r.in_ack && s_r.sda_sy[1]) begin
               s_nxt.phase = I_IDLE;
            end else if (!s_r.in_ack) begin
               s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
            end
         end else if (!s_r.in_ack) begin
            s_nxt.shift   = {s_r.shift[6:0], s_r.sda_sy[1]};
            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
         end
      end else if (s_r.phase != I_IDLE && scl_fall) begin
         if (s_r.in_ack) begin
            s_nxt.in_ack  = 1'b0;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.drive   = 1'b0;
            if (s_r.phase == I_RD) begin
               s_nxt.shift = rdata;
               s_nxt.drive = ~rdata[7];
               s_nxt.ptr   = s_r.ptr + 8'h01;
            end
         end else if (s_r.phase == I_RD) begin
            if (s_r.bit_cnt == 4'h8) begin
               s_nxt.drive  = 1'b0;
               s_nxt.in_ack = 1'b1;
            end else begin
               s_nxt.shift = {s_r.shift[6:0], 1'b0};
               s_nxt.drive = ~s_r.shift[6];
            end
         end else if (s_r.bit_cnt == 4'h8) begin
            s_nxt.in_ack = 1'b1;
            s_nxt.drive  = 1'b1;
            unique case (s_r.phase)
               I_ADDR: begin
                  if (s_r.shift[7:1] == DEV_ADDR) begin
                     s_nxt.phase = s_r.shift[0] ? I_RD : I_PTR;
                  end else begin
                     s_nxt.phase  = I_IDLE;
                     s_nxt.in_ack = 1'b0;
                     s_nxt.drive  = 1'b0;
                  end
               end
               I_PTR: begin
                  s_nxt.ptr   = s_r.shift;
                  s_nxt.phase = I_WR;
               end
               I_WR: begin
                  wr_stb    = 1'b1;
                  s_nxt.ptr = s_r.ptr + 8'h01;
                  if (sel[4]) begin
                     s_nxt.regs[sel[3:0]] = s_r.shift & REG_MSK[sel[3:0]];
                  end
               end
               default: begin
                  s_nxt.phase = I_IDLE;
               end
            endcase
         end
      end

      // effective high gate code keeps the margin over the positive source
      need_mv = PS_BASE_MV + PS_STEP_MV * int'(s_r.regs[IDX_POS_LEVEL][5:0])
              + HG_MARGIN_MV - HG_BASE_MV;
      min_code = (need_mv <= 0) ? 0 : (need_mv + HG_STEP_MV - 1) / HG_STEP_MV;
      hg_min   = (min_code > 63) ? 6'h3f : 6'(min_code);
      s_nxt.hg_eff = (s_r.regs[IDX_HG_LEVEL][5:0] < hg_min) ? hg_min
                   : s_r.regs[IDX_HG_LEVEL][5:0];

      // timer intervals in milliseconds
      tmr_ms[T_POS] = 8'(int'(s_r.regs[IDX_POS_DELAY][3:0]) * DELAY_STEP_MS);
      tmr_ms[T_NS]  = 8'(int'(s_r.regs[IDX_NS_DELAY][3:0]) * DELAY_STEP_MS);
      tmr_ms[T_LGD] = 8'(int'(s_r.regs[IDX_LG_DELAY][3:0]) * DELAY_STEP_MS);
      tmr_ms[T_LGR] = 8'((int'(s_r.regs[IDX_LG_RAMP][2:0]) + 1) * LG_RAMP_STEP_MS);

      // positive source: delay then run
      unique case (s_r.pos_st)
         S_IDLE: begin
            if (load_done_i) begin
               tmr_start[T_POS] = 1'b1;
               s_nxt.pos_st     = S_DELAY;
            end
         end
         S_DELAY: begin
            if (tmr_done[T_POS]) begin
               s_nxt.pos_st  = S_DONE;
               s_nxt.pos_run = 1'b1;
            end
         end
         default: begin
            s_nxt.pos_st = S_DONE;
         end
      endcase

      // low gate: delay from positive ramp start, then timed ramp
      unique case (s_r.lg_st)
         S_IDLE: begin
            if (s_r.pos_st == S_DELAY && tmr_done[T_POS]) begin
               if (s_r.regs[IDX_LG_DELAY][3:0] == 4'h0) begin
                  s_nxt.lg_st = S_WAIT;
               end else begin
                  tmr_start[T_LGD] = 1'b1;
                  s_nxt.lg_st      = S_DELAY;
               end
            end
         end
         S_DELAY, S_WAIT: begin
            if ((s_r.lg_st == S_DELAY && tmr_done[T_LGD]) ||
                (s_r.lg_st == S_WAIT && s_r.pre_sy[1])) begin
               tmr_start[T_LGR] = 1'b1;
               s_nxt.lg_st      = S_RAMP;
               s_nxt.lg_run     = 1'b1;
               s_nxt.lg_ramping = 1'b1;
            end
         end
         S_RAMP: begin
            if (tmr_done[T_LGR]) begin
               s_nxt.lg_st      = S_DONE;
               s_nxt.lg_ramping = 1'b0;
               s_nxt.lg_ready   = 1'b1;
            end
         end
         S_DONE: begin
            s_nxt.lg_st = S_DONE;
         end
         default: begin
            s_nxt.lg_st = S_IDLE;
         end
      endcase

      // negative source: delay from load, ramp until ready
      unique case (s_r.ns_st)
         S_IDLE: begin
            if (load_done_i) begin
               tmr_start[T_NS] = 1'b1;
               s_nxt.ns_st     = S_DELAY;
            end
         end
         S_DELAY: begin
            if (tmr_done[T_NS]) begin
               s_nxt.ns_st      = S_RAMP;
               s_nxt.ns_run     = 1'b1;
               s_nxt.ns_ramping = 1'b1;
            end
         end
         S_RAMP: begin
            if (s_r.rdy_sy[1]) begin
               s_nxt.ns_st      = S_DONE;
               s_nxt.ns_ramping = 1'b0;
            end
         end
         default: begin
            s_nxt.ns_st = S_DONE;
         end
      endcase
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_r        <= '0;
         s_r.scl_sy <= 2'h3;
         s_r.sda_sy <= 2'h3;
         s_r.scl_d  <= 1'b1;
         s_r.sda_d  <= 1'b1;
         s_r.phase  <= I_IDLE;
         s_r.pos_st <= S_IDLE;
         s_r.lg_st  <= S_IDLE;
         s_r.ns_st  <= S_IDLE;
         s_r.hg_eff <= RST_HG_LEVEL[5:0];
         for (int i = 0; i < NUM_REGS; i++) begin
            s_r.regs[i] <= REG_RST[i];
         end
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign sda_o                  = 1'b0;
   assign sda_oe_n_o             = ~s_r.drive;
   assign pos_source_level_o     = s_r.regs[IDX_POS_LEVEL][5:0];
   assign high_gate_level_o      = s_r.hg_eff;
   assign cold_gate_offset_o     = s_r.regs[IDX_HG_COLD][4:0];
   assign low_gate_level_o       = s_r.regs[IDX_LG_LEVEL][5:0];
   assign pump_ext_mode_o        = s_r.regs[IDX_PUMP_CFG][PUMP_EXT_BIT];
   assign low_gate_ramp_code_o   = s_r.regs[IDX_LG_RAMP][2:0];
   assign neg_source_ramp_code_o = s_r.regs[IDX_NS_RAMP][2:0];
   assign pos_source_run_o       = s_r.pos_run;
   assign low_gate_run_o         = s_r.lg_run;
   assign low_gate_ramping_o     = s_r.lg_ramping;
   assign low_gate_ready_o       = s_r.lg_ready;
   assign neg_source_run_o       = s_r.ns_run;
   assign neg_source_ramping_o   = s_r.ns_ramping;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   logic stop_now;
   assign stop_now = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sy[1];

   sequence lg_ramp_over;
      s_r.lg_st == S_RAMP && tmr_done[T_LGR];
   endsequence
   sequence lg_ready_shown;
      low_gate_ready_o && !low_gate_ramping_o;
   endsequence

   chk_hg_margin: assert property (##1 high_gate_level_o >= $past(hg_min))
      else $error("high gate code below source margin");
   chk_lg_zero_hold: assert property (s_r.lg_st == S_WAIT && !s_r.pre_sy[1] |=>
      !low_gate_run_o)
      else $error("low gate started before precharge done");
   chk_lg_delay_start: assert property (s_r.lg_st == S_IDLE && s_r.pos_st == S_DELAY &&
      tmr_done[T_POS] && s_r.regs[IDX_LG_DELAY][3:0] != 4'h0 |=> s_r.lg_st == S_DELAY)
      else $error("low gate delay did not start with positive ramp");
   chk_lg_ramp_end: assert property (lg_ramp_over |=> lg_ready_shown)
      else $error("low gate ramp end not shown");
   chk_ns_ready_end: assert property (s_r.ns_st == S_RAMP && s_r.rdy_sy[1] |=>
      !neg_source_ramping_o && neg_source_run_o)
      else $error("negative source ramp did not end on ready");
   chk_ns_load_start: assert property (s_r.ns_st == S_IDLE && load_done_i |=>
      s_r.ns_st == S_DELAY && !neg_source_run_o)
      else $error("negative source delay did not start on load");
   chk_reg_write: assert property (wr_stb && reg_index(s_r.ptr) == {1'b1, 4'(IDX_PUMP_CFG)} |=>
      pump_ext_mode_o == $past(s_r.shift[PUMP_EXT_BIT]))
      else $error("pump topology write not applied");
   chk_addr_ack: assert property (s_r.phase == I_ADDR && !s_r.in_ack && s_r.bit_cnt == 4'h8 &&
      !s_r.scl_sy[1] && s_r.scl_d && s_r.shift[7:1] == DEV_ADDR && !stop_now |=> !sda_oe_n_o)
      else $error("own address not acknowledged");
   chk_pos_run: assert property (s_r.pos_st == S_DELAY && tmr_done[T_POS] |=>
      pos_source_run_o ##1 pos_source_run_o)
      else $error("positive source not started after delay");

endmodule
